// file: src/clkmon_regs.svh
// Register offsets, field positions, reset values and timing counts of the clock monitor.
`ifndef CLKMON_REGS_SVH
`define CLKMON_REGS_SVH

`define ADDR_CLK_DIV      3'h0
`define ADDR_SETPOINT     3'h1
`define ADDR_DIAG         3'h2
`define ADDR_FAULT_CFG    3'h3
`define ADDR_VERSION      3'h4

`define DIV_RATIO_MSB     3
`define DIV_WDOG_BIT      4
`define DIV_RATIO_RST     4'h8

`define DIAG_RST_OCC_BIT  2
`define DIAG_FAULT_BIT    3
`define DIAG_PIN_LOW_BIT  4

`define CFG_MASK_BIT      0
`define CFG_MASK_RST      1'b1

`define VER_WDOG_BIT      7

`define CLK_PERIOD_NS     40
`define MISS_CLK_NS       2000
`define MISS_CLK_CYC      (`MISS_CLK_NS / `CLK_PERIOD_NS)

`endif

// file: src/clkmon_pkg.sv
// Types shared by the clock monitor, reset and fault control block.
package clkmon_pkg;

	typedef struct packed {
		logic       valid;
		logic       write;
		logic [2:0] addr;
		logic [7:0] data;
	} spi_cmd_s;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} spi_rsp_s;

	typedef enum logic [2:0] {
		ST_RUN  = 3'b001,
		ST_HOLD = 3'b010,
		ST_TRIP = 3'b100
	} ctrl_state_e;

endpackage

// file: src/edge_gap_timer.sv
// Measures the time between rising edges of the external clock on the local timebase.
module edge_gap_timer #(
	parameter int MISS_CYC = 50,
	parameter int CNT_W    = 12
) (
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic clk_in,
	output logic      rise,
	output logic      gap
);

	logic             clk_in_q;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic             sat;

	localparam logic [CNT_W-1:0] MISS_LIM = CNT_W'(MISS_CYC);

	assign rise  = clk_in & ~clk_in_q;
	assign sat   = (cnt_q > MISS_LIM);
	assign cnt_d = rise ? '0 : (sat ? cnt_q : cnt_q + 1'b1);
	assign gap   = sat;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			clk_in_q <= 1'b0;
			cnt_q    <= '0;
		end else begin
			clk_in_q <= clk_in;
			cnt_q    <= cnt_d;
		end
	end

endmodule

// file: src/clock_monitor_reset_fault_ctrl.sv
// Clock divider, missing clock watchdog, reset holding and fault line control of a two channel driver.
`include "clkmon_regs.svh"

module clock_monitor_reset_fault_ctrl
	import clkmon_pkg::*;
#(
	parameter int         RATIO_W    = 4,
	parameter logic [3:0] VERSION_ID = 4'h5 // Arbitrary value.
) (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       ext_clk_in,
	input  wire logic       ext_reset_n,
	input  wire logic       enable_pin,
	input  wire logic       analog_supply_uv,
	input  wire logic       reference_supply_uv,
	input  wire logic [1:0] load_supply_uv,
	input  wire logic       diag_fault,
	input  wire logic       fault_pin_in,
	input  wire spi_cmd_s   spi_cmd,
	output spi_rsp_s        spi_rsp,
	output logic            sys_tick,
	output logic [1:0]      stage_on,
	output logic            fault_out_n,
	output logic            fault_oe,
	output logic            spi_active,
	output logic            logic_in_reset
);

	ctrl_state_e        state_q;
	ctrl_state_e        state_d;
	logic [RATIO_W-1:0] div_ratio_q;
	logic [RATIO_W-1:0] div_ratio_d;
	logic [RATIO_W-1:0] div_cnt_q;
	logic [RATIO_W-1:0] div_cnt_d;
	logic               clk_watchdog_on_q;
	logic               clk_watchdog_on_d;
	logic               div_written_q;
	logic               div_written_d;
	logic [1:0]         setpt_en_q;
	logic [1:0]         setpt_en_d;
	logic               enable_fault_mask_q;
	logic               enable_fault_mask_d;
	logic [1:0]         load_supply_uv_flag_q;
	logic [1:0]         load_supply_uv_flag_d;
	logic               rst_occ_q;
	logic               rst_occ_d;
	logic               sys_tick_q;
	logic [1:0]         stage_on_q;
	logic               fault_oe_q;
	spi_rsp_s           spi_rsp_q;

	logic               ext_rise;
	logic               clk_gap;
	logic               hold_req;
	logic               in_reset;
	logic               exit_reset;
	logic               wr_ok;
	logic               wr_div;
	logic               wr_setpt;
	logic               wr_cfg;
	logic               diag_access;
	logic               div_tick;
	logic               stage_gate;
	logic               fault_low;
	logic [7:0]         version_word;
	logic [7:0]         reg_word;
	logic [7:0]         rd_word;

	function automatic logic [RATIO_W-1:0] ratio_last(input logic [RATIO_W-1:0] r);
		ratio_last = (r == '0) ? '0 : r - 1'b1;
	endfunction

	edge_gap_timer #(
		.MISS_CYC (`MISS_CLK_CYC),
		.CNT_W    (12)
	) u_gap (
		.clk    (clk),
		.rst_b  (rst_b),
		.clk_in (ext_clk_in),
		.rise   (ext_rise),
		.gap    (clk_gap)
	);

	// Control state: run, held in reset by the reset pin or the analog or reference supply, or tripped by the watchdog.
	assign hold_req   = ~ext_reset_n | analog_supply_uv | reference_supply_uv;
	assign in_reset   = (state_q != ST_RUN);
	assign exit_reset = (state_q == ST_HOLD) && (state_d == ST_RUN);

	always_comb begin
		state_d = state_q;
		if (hold_req) begin
			state_d = ST_HOLD;
		end else begin
			case (state_q)
				ST_RUN: begin
					if (clk_watchdog_on_q && clk_gap) begin
						state_d = ST_TRIP;
					end
				end
				ST_HOLD: begin
					state_d = ST_RUN;
				end
				ST_TRIP: begin
					state_d = ST_TRIP;
				end
				default: begin
					state_d = ST_HOLD;
				end
			endcase
		end
	end

	// Register access decode.
	assign spi_active  = (state_q != ST_HOLD);
	assign wr_ok       = spi_cmd.valid & spi_cmd.write & (state_q == ST_RUN) & ~clk_gap;
	assign wr_div      = wr_ok & (spi_cmd.addr == `ADDR_CLK_DIV);
	assign wr_setpt    = wr_ok & (spi_cmd.addr == `ADDR_SETPOINT);
	assign wr_cfg      = wr_ok & (spi_cmd.addr == `ADDR_FAULT_CFG);
	assign diag_access = spi_cmd.valid & spi_active & (spi_cmd.addr == `ADDR_DIAG);

	assign div_ratio_d         = in_reset ? `DIV_RATIO_RST :
	                             (wr_div ? spi_cmd.data[`DIV_RATIO_MSB:0] : div_ratio_q);
	assign clk_watchdog_on_d   = in_reset ? 1'b0 : (wr_div ? spi_cmd.data[`DIV_WDOG_BIT] : clk_watchdog_on_q);
	assign div_written_d       = ~in_reset & (wr_div | div_written_q);
	assign setpt_en_d          = (in_reset | ~enable_pin) ? 2'b00 :
	                             (wr_setpt ? spi_cmd.data[1:0] : setpt_en_q);
	assign enable_fault_mask_d = in_reset ? `CFG_MASK_RST :
	                             (wr_cfg ? spi_cmd.data[`CFG_MASK_BIT] : enable_fault_mask_q);
	assign load_supply_uv_flag_d = in_reset ? 2'b00 :
	                               (load_supply_uv | (load_supply_uv_flag_q & {2{~diag_access}}));
	assign rst_occ_d           = exit_reset | (~in_reset & rst_occ_q & ~diag_access);

	// System tick from the external clock edges.
	assign div_tick  = ext_rise & (div_cnt_q >= ratio_last(div_ratio_q));
	assign div_cnt_d = (state_q == ST_HOLD) ? '0 : (div_tick ? '0 : (ext_rise ? div_cnt_q + 1'b1 : div_cnt_q));

	// Output stage gating and fault line.
	assign stage_gate = ~in_reset & enable_pin & clk_watchdog_on_q & div_written_q & ~clk_gap;
	assign fault_low  = in_reset | diag_fault | (|load_supply_uv)
	                  | (~enable_pin & enable_fault_mask_q);

	// Read data.
	assign version_word = {(state_q == ST_TRIP), 3'b000, VERSION_ID};
	always_comb begin
		case (spi_cmd.addr)
			`ADDR_CLK_DIV:   reg_word = {3'b000, clk_watchdog_on_q, div_ratio_q};
			`ADDR_SETPOINT:  reg_word = {6'b00_0000, setpt_en_q};
			`ADDR_DIAG:      reg_word = {3'b000, ~fault_pin_in, diag_fault, rst_occ_q, load_supply_uv_flag_q};
			`ADDR_FAULT_CFG: reg_word = {7'b000_0000, enable_fault_mask_q};
			`ADDR_VERSION:   reg_word = version_word;
			default:         reg_word = 8'h00;
		endcase
	end
	assign rd_word = clk_gap ? version_word : reg_word;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= ST_HOLD;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			div_ratio_q         <= `DIV_RATIO_RST;
			div_cnt_q           <= '0;
			clk_watchdog_on_q   <= 1'b0;
			div_written_q       <= 1'b0;
			setpt_en_q          <= 2'b00;
			enable_fault_mask_q <= `CFG_MASK_RST;
		end else begin
			div_ratio_q         <= div_ratio_d;
			div_cnt_q           <= div_cnt_d;
			clk_watchdog_on_q   <= clk_watchdog_on_d;
			div_written_q       <= div_written_d;
			setpt_en_q          <= setpt_en_d;
			enable_fault_mask_q <= enable_fault_mask_d;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			load_supply_uv_flag_q <= 2'b00;
			rst_occ_q             <= 1'b0;
			sys_tick_q            <= 1'b0;
			stage_on_q            <= 2'b00;
			fault_oe_q            <= 1'b1;
			spi_rsp_q             <= '0;
		end else begin
			load_supply_uv_flag_q <= load_supply_uv_flag_d;
			rst_occ_q             <= rst_occ_d;
			sys_tick_q            <= div_tick;
			stage_on_q            <= setpt_en_q & ~load_supply_uv & {2{stage_gate}};
			fault_oe_q            <= fault_low;
			spi_rsp_q.valid       <= spi_cmd.valid & spi_active;
			spi_rsp_q.data        <= (spi_cmd.valid & spi_active) ? rd_word : 8'h00;
		end
	end

	assign sys_tick       = sys_tick_q;
	assign stage_on       = stage_on_q;
	assign fault_out_n    = 1'b0;
	assign fault_oe       = fault_oe_q;
	assign spi_rsp        = spi_rsp_q;
	assign logic_in_reset = in_reset;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	property p_tick_on_edge;
		sys_tick |-> $past(ext_rise);
	endproperty
	a_tick_on_edge: assert property (p_tick_on_edge) else $error("tick without clock edge");

	property p_div_first;
		(stage_on != 2'b00) |-> $past(div_written_q, 1);
	endproperty
	a_div_first: assert property (p_div_first) else $error("stage on before divider written");

	property p_trip;
		(state_q == ST_RUN) && clk_watchdog_on_q && clk_gap && !hold_req |=> (state_q == ST_TRIP);
	endproperty
	a_trip: assert property (p_trip) else $error("missing clock did not trip");

	property p_wd_off_exit;
		(state_q == ST_HOLD) ##1 (state_q == ST_RUN) |-> !clk_watchdog_on_q;
	endproperty
	a_wd_off_exit: assert property (p_wd_off_exit) else $error("watchdog on after reset");

	property p_wd_gate;
		!clk_watchdog_on_q |=> (stage_on == 2'b00);
	endproperty
	a_wd_gate: assert property (p_wd_gate) else $error("stage on with watchdog off");

	property p_trip_effects;
		(state_q == ST_TRIP) && !hold_req |=> fault_oe && (stage_on == 2'b00) && version_word[`VER_WDOG_BIT];
	endproperty
	a_trip_effects: assert property (p_trip_effects) else $error("trip effects missing");

	property p_gap_version;
		spi_cmd.valid && spi_active && clk_gap |=> spi_rsp.valid && (spi_rsp.data == $past(version_word));
	endproperty
	a_gap_version: assert property (p_gap_version) else $error("absent clock answer not version");

	property p_div_revert;
		(state_q == ST_TRIP) |=> (div_ratio_q == `DIV_RATIO_RST);
	endproperty
	a_div_revert: assert property (p_div_revert) else $error("ratio not back to eight");

	property p_no_write_trip;
		(state_q == ST_TRIP) [*3] |-> $stable(enable_fault_mask_q) && $stable(div_ratio_q);
	endproperty
	a_no_write_trip: assert property (p_no_write_trip) else $error("write taken after trip");

	property p_trip_sticky;
		(state_q == ST_TRIP) && !hold_req |=> (state_q == ST_TRIP);
	endproperty
	a_trip_sticky: assert property (p_trip_sticky) else $error("trip released");

	property p_en_low;
		!enable_pin && enable_fault_mask_q |=> fault_oe ##0 (setpt_en_q == 2'b00) ##1 (stage_on == 2'b00);
	endproperty
	a_en_low: assert property (p_en_low) else $error("enable low not honoured");

	property p_ext_reset_n;
		!ext_reset_n |=> !spi_active ##1 fault_oe;
	endproperty
	a_ext_reset_n: assert property (p_ext_reset_n) else $error("reset pin not honoured");

	property p_uv_chan;
		(load_supply_uv != 2'b00) && !in_reset |=> ((stage_on & $past(load_supply_uv)) == 2'b00)
			&& ((load_supply_uv_flag_q & $past(load_supply_uv)) == $past(load_supply_uv));
	endproperty
	a_uv_chan: assert property (p_uv_chan) else $error("channel undervoltage not honoured");

	property p_supply_hold;
		analog_supply_uv || reference_supply_uv |=> (state_q == ST_HOLD) ##1 fault_oe;
	endproperty
	a_supply_hold: assert property (p_supply_hold) else $error("supply undervoltage not held");

	property p_rst_occ;
		(state_q == ST_HOLD) ##1 (state_q == ST_RUN) |-> rst_occ_q;
	endproperty
	a_rst_occ: assert property (p_rst_occ) else $error("reset flag not set on exit");

	property p_trip_reads;
		(state_q == ST_TRIP) && ($past(state_q) == ST_TRIP) && !clk_gap && spi_cmd.valid
			&& (spi_cmd.addr == `ADDR_CLK_DIV) |=> (spi_rsp.data == {4'h0, `DIV_RATIO_RST});
	endproperty
	a_trip_reads: assert property (p_trip_reads) else $error("register not at reset value after trip");

	property p_en_keep;
		!enable_pin && !in_reset && !wr_ok |=> $stable(div_ratio_q) && $stable(enable_fault_mask_q)
			&& $stable(clk_watchdog_on_q);
	endproperty
	a_en_keep: assert property (p_en_keep) else $error("register changed while enable low");

	property p_en_bits_zero;
		!enable_pin |=> (setpt_en_q == 2'b00);
	endproperty
	a_en_bits_zero: assert property (p_en_bits_zero) else $error("channel enable kept with pin low");

	property p_gap_no_write;
		clk_gap |=> $stable(setpt_en_q) || (setpt_en_q == 2'b00);
	endproperty
	a_gap_no_write: assert property (p_gap_no_write) else $error("write taken with clock missing");

	property p_fault_release;
		!in_reset && !diag_fault && (load_supply_uv == 2'b00) && (enable_pin || !enable_fault_mask_q) |=> !fault_oe;
	endproperty
	a_fault_release: assert property (p_fault_release) else $error("fault line held without cause");

	property p_rst_occ_clear;
		diag_access && !exit_reset |=> !rst_occ_q;
	endproperty
	a_rst_occ_clear: assert property (p_rst_occ_clear) else $error("reset flag not cleared on access");

	property p_gap_limit;
		ext_rise |=> !clk_gap;
	endproperty
	a_gap_limit: assert property (p_gap_limit) else $error("gap flagged right after an edge");

	c_trip:   cover property ((state_q == ST_RUN) ##1 (state_q == ST_TRIP));
	c_trip_rd: cover property ((state_q == ST_TRIP) && spi_cmd.valid && !clk_gap);
	c_stage:  cover property (stage_on == 2'b11);
	c_exit:   cover property ((state_q == ST_TRIP) ##1 (state_q == ST_HOLD) ##1 (state_q == ST_RUN));
	c_en_cut: cover property ((stage_on != 2'b00) ##1 !enable_pin);

endmodule

// file: tb/host_pin_model.sv
// Host side model driving the clock, enable and reset pins and sensing the fault line.
module host_pin_model #(
	parameter int HALF = 2
) (
	input  wire logic clk,
	input  wire logic clk_run,
	input  wire logic req_en,
	input  wire logic req_rst_n,
	input  wire logic fault_oe,
	input  wire logic fault_out_n,
	output logic      ext_clk_in,
	output logic      enable_pin,
	output logic      ext_reset_n,
	output logic      fault_pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	int   cnt_q = 0;
	logic pin_q = 1'b0;
	// A stopped clock sits low on its pull-down.
	always @(negedge clk) begin
		if (!clk_run) begin
			pin_q <= 1'b0;
			cnt_q <= 0;
		end else if (cnt_q == HALF - 1) begin
			pin_q <= ~pin_q;
			cnt_q <= 0;
		end else begin
			cnt_q <= cnt_q + 1;
		end
	end
	assign ext_clk_in = pin_q;
	assign enable_pin = req_en;
	assign ext_reset_n = req_rst_n;
	// Open-drain line with pull-up.
	assign fault_pin_in = fault_oe ? fault_out_n : 1'b1;
endmodule

// file: tb/clock_monitor_reset_fault_ctrl_tb_top.sv
// Self-checking testbench of the clock monitor, reset and fault control block.
`include "clkmon_regs.svh"
module clock_monitor_reset_fault_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import clkmon_pkg::*;
	localparam int EXT_PER = 4;
	logic       clk = 1'b0;
	logic       rst_b = 1'b0;
	logic       clk_run = 1'b1;
	logic       req_en = 1'b1;
	logic       req_rst_n = 1'b1;
	logic       ana_uv = 1'b0;
	logic       ref_uv = 1'b0;
	logic [1:0] load_uv = 2'b00;
	logic       dfault = 1'b0;
	spi_cmd_s   spi_cmd = '0;
	spi_rsp_s   spi_rsp;
	logic       ext_clk_in, ext_reset_n, enable_pin, fault_pin_in;
	logic       sys_tick, fault_out_n, fault_oe, spi_active, logic_in_reset;
	logic [1:0] stage_on;
	logic [7:0] pins;
	int         err_count = 0;
	int         num_checks = 0;
	int         gap;
	assign pins = {3'h0, spi_active, logic_in_reset, fault_oe, stage_on};
	always #20 clk = ~clk;
	host_pin_model #(.HALF(EXT_PER / 2)) i_host_pin_model (.clk(clk), .clk_run(clk_run), .req_en(req_en),
		.req_rst_n(req_rst_n), .fault_oe(fault_oe), .fault_out_n(fault_out_n), .ext_clk_in(ext_clk_in),
		.enable_pin(enable_pin), .ext_reset_n(ext_reset_n), .fault_pin_in(fault_pin_in));
	clock_monitor_reset_fault_ctrl i_clock_monitor_reset_fault_ctrl (.clk(clk), .rst_b(rst_b),
		.ext_clk_in(ext_clk_in), .ext_reset_n(ext_reset_n), .enable_pin(enable_pin), .analog_supply_uv(ana_uv),
		.reference_supply_uv(ref_uv), .load_supply_uv(load_uv), .diag_fault(dfault), .fault_pin_in(fault_pin_in),
		.spi_cmd(spi_cmd), .spi_rsp(spi_rsp), .sys_tick(sys_tick), .stage_on(stage_on), .fault_out_n(fault_out_n),
		.fault_oe(fault_oe), .spi_active(spi_active), .logic_in_reset(logic_in_reset));
	task automatic ck(input string n, input logic [7:0] s, input logic [7:0] e);
		num_checks++;
		if (s !== e) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic xfer(input logic w, input logic [2:0] a, input logic [7:0] d, output logic [7:0] q,
		output logic ok);
		ok = 1'b0;
		q = 8'h00;
		@(negedge clk);
		spi_cmd = '{1'b1, w, a, d};
		@(negedge clk);
		spi_cmd.valid = 1'b0;
		for (int i = 0; i < 3 && !ok; i++) begin
			if (spi_rsp.valid === 1'b1) begin
				ok = 1'b1;
				q = spi_rsp.data;
			end else begin
				@(negedge clk);
			end
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		logic [7:0] q;
		logic       ok;
		xfer(1'b1, a, d, q, ok);
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e, input string n);
		logic [7:0] q;
		logic       ok;
		xfer(1'b0, a, 8'h00, q, ok);
		ck(n, q, e);
	endtask
	task automatic pins_ck(input int cyc, input logic [7:0] e);
		repeat (cyc) @(negedge clk);
		ck("pins", pins, e);
	endtask
	task automatic tick_gap(output int n);
		n = 0;
		for (int i = 0; i < 100 && sys_tick !== 1'b1; i++) @(negedge clk);
		@(negedge clk);
		for (int i = 0; i < 100 && sys_tick !== 1'b1; i++) begin
			@(negedge clk);
			n++;
		end
		n++;
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		final_report();
	end
	initial begin
		repeat (20) @(negedge clk);
		rst_b = 1'b1;
		pins_ck(4, 8'h10);
		rd(`ADDR_CLK_DIV, 8'h08, "div");
		rd(`ADDR_SETPOINT, 8'h00, "setpt");
		rd(`ADDR_FAULT_CFG, 8'h01, "cfg");
		rd(`ADDR_VERSION, 8'h05, "ver");
		rd(`ADDR_DIAG, 8'h04, "diag");
		rd(`ADDR_DIAG, 8'h00, "diag");
		$display("test reset_values done");
		wr(`ADDR_SETPOINT, 8'h03);
		pins_ck(2, 8'h10);
		wr(`ADDR_CLK_DIV, 8'h02);
		pins_ck(2, 8'h10);
		wr(`ADDR_CLK_DIV, 8'h12);
		pins_ck(2, 8'h13);
		for (int r = 2; r <= 3; r++) begin
			wr(`ADDR_CLK_DIV, 8'(8'h10 + r));
			tick_gap(gap);
			ck("tick", 8'(gap), 8'(r * EXT_PER));
		end
		$display("test divider done");
		req_en = 1'b0;
		pins_ck(2, 8'h14);
		rd(`ADDR_SETPOINT, 8'h00, "setpt");
		rd(`ADDR_CLK_DIV, 8'h13, "div");
		wr(`ADDR_FAULT_CFG, 8'h00);
		pins_ck(2, 8'h10);
		wr(`ADDR_SETPOINT, 8'h03);
		rd(`ADDR_SETPOINT, 8'h00, "setpt");
		req_en = 1'b1;
		pins_ck(2, 8'h10);
		rd(`ADDR_SETPOINT, 8'h00, "setpt");
		wr(`ADDR_FAULT_CFG, 8'h01);
		wr(`ADDR_SETPOINT, 8'h01);
		pins_ck(2, 8'h11);
		$display("test enable_pin done");
		wr(`ADDR_SETPOINT, 8'h03);
		load_uv = 2'b10;
		pins_ck(2, 8'h15);
		rd(`ADDR_DIAG, 8'h12, "diag");
		load_uv = 2'b00;
		pins_ck(2, 8'h13);
		rd(`ADDR_DIAG, 8'h02, "diag");
		rd(`ADDR_DIAG, 8'h00, "diag");
		dfault = 1'b1;
		pins_ck(2, 8'h17);
		rd(`ADDR_DIAG, 8'h18, "diag");
		dfault = 1'b0;
		$display("test faults done");
		clk_run = 1'b0;
		pins_ck(70, 8'h1C);
		rd(`ADDR_SETPOINT, 8'h85, "ver");
		wr(`ADDR_CLK_DIV, 8'h03);
		clk_run = 1'b1;
		pins_ck(10, 8'h1C);
		rd(`ADDR_CLK_DIV, 8'h08, "div");
		rd(`ADDR_SETPOINT, 8'h00, "setpt");
		rd(`ADDR_VERSION, 8'h85, "ver");
		wr(`ADDR_SETPOINT, 8'h03);
		rd(`ADDR_SETPOINT, 8'h00, "setpt");
		tick_gap(gap);
		ck("tick", 8'(gap), 8'(8 * EXT_PER));
		pins_ck(1, 8'h1C);
		$display("test watchdog_trip done");
		begin
			logic [7:0] q;
			logic       ok;
			req_rst_n = 1'b0;
			pins_ck(3, 8'h0C);
			xfer(1'b0, `ADDR_VERSION, 8'h00, q, ok);
			ck("answer", 8'(ok), 8'h00);
		end
		req_rst_n = 1'b1;
		pins_ck(4, 8'h10);
		rd(`ADDR_VERSION, 8'h05, "ver");
		rd(`ADDR_DIAG, 8'h04, "diag");
		rd(`ADDR_CLK_DIV, 8'h08, "div");
		$display("test reset_pin done");
		for (int i = 0; i < 2; i++) begin
			ana_uv = (i == 0);
			ref_uv = (i == 1);
			pins_ck(3, 8'h0C);
			ana_uv = 1'b0;
			ref_uv = 1'b0;
			pins_ck(4, 8'h10);
			rd(`ADDR_DIAG, 8'h04, "diag");
		end
		$display("test supplies done");
		final_report();
	end
endmodule
